//--- verilog/udrt_defines.vh
/*
 * Constants of the 8-bit up/down reload timer: register word addresses,
 * mode register fields, reset values and prescaler taps.
 * Assumes a 32-bit Avalon-MM slave with word addresses (byte address / 4).
 */
// Notes on behaviour
// - Writing reload value also loads counter
// - Auto-reload mode reloads counter on wrap
// - Reload and counter share one address
// - Reset clears reload register to zero
// - Mode bit picks interval or auto-reload
// - Reset: counter zero, mode 0x18, counts up
// - Clock select picks prescaler tap, watch/4 or pin
// - Two mode bits govern count direction
// - Wrap past FF or 00 raises request
// - Interval mode wraps to 00 or FF
// - Select 111 counts external pin edges
// - Direction pin high counts down
// - Sub modes count only pin or watch/4
// - Watch/4 clock synchronised to system clock
// - Watch/8 subclock steps count by two, LSB held
// - Direction code 00 up, 01 down, 1x pin
// - Clock codes: /8192../4, watch/4, pin
`ifndef UDRT_DEFINES_VH
`define UDRT_DEFINES_VH

`define UDRT_ADDR_MODE      2'h0
`define UDRT_ADDR_COUNT     2'h1
`define UDRT_ADDR_STATUS    2'h2

`define UDRT_MODE_RESET     8'h18
`define UDRT_MODE_RSVD_MASK 8'h18
`define UDRT_COUNT_RESET    8'h00
`define UDRT_RELOAD_RESET   8'h00

`define UDRT_BIT_AUTORELOAD 7
`define UDRT_BIT_HW_DIR     6
`define UDRT_BIT_SW_DIR     5
`define UDRT_CSEL_MSB       2
`define UDRT_CSEL_LSB       0

`define UDRT_CSEL_WATCH4    3'h6
`define UDRT_CSEL_EXT       3'h7

`define UDRT_DIV_8192       8192
`define UDRT_DIV_2048       2048
`define UDRT_DIV_512        512
`define UDRT_DIV_64         64
`define UDRT_DIV_16         16
`define UDRT_DIV_4          4

`endif

//--- verilog/udrt_sync_edge.v
/*
 * Two-flop synchroniser with edge detector for an asynchronous input.
 * Assumes CLK is the system clock and the input is slow against it.
 */
`timescale 1ns/1ns
module udrt_sync_edge
(
    input  wire clk,
    input  wire rst_n,
    input  wire async_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
    assign fall  = ~sync_ff & last_ff;
endmodule // udrt_sync_edge

//--- verilog/udrt_timer.v
/*
 * 8-bit up/down timer with interval and auto-reload modes, Avalon-MM slave.
 * Assumes pins arrive asynchronous; the interrupt controller outside holds
 * the request flag and its enable and catches WRAP_PULSE.
 */
`timescale 1ns/1ns
`include "udrt_defines.vh"
module udrt_timer
#(
    parameter DIV_8192 = `UDRT_DIV_8192
)
(
    input  wire        CLK,
    input  wire        RST_N,
    input  wire [1:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    input  wire        EVENT_INPUT_PIN,
    input  wire        EVENT_EDGE_RISING,
    input  wire        COUNT_DIRECTION_PIN,
    input  wire        WATCH_CLK_DIV4,
    input  wire        SUB_MODE,
    input  wire        WATCH_SUB_DIV8,
    output reg         WRAP_PULSE,
    output reg  [7:0]  COUNT_VALUE,
    output reg         COUNT_DOWN
);
    reg  [12:0] presc_ff;
    reg  [7:0]  timer_mode_ctl_ff;
    reg  [7:0]  reload_value_ff;
    reg  [7:0]  count_value_ff;
    reg  [7:0]  nxt_count;
    reg         ack_ff;
    reg         tick;
    reg         down;
    reg         wrap;
    wire        ev_level;
    wire        ev_rise;
    wire        ev_fall;
    wire        ud_level;
    wire        w4_rise;
    wire [2:0]  clock_source_select;
    wire        autoreload_select;
    wire        load_write;

    function presc_tap;
        input [12:0] cnt;
        input [31:0] div;
        begin
            presc_tap = ((cnt & (div[12:0] - 13'h0001)) == 13'h0000);
        end
    endfunction

    udrt_sync_edge u_ev
    (
        .clk      (CLK),
        .rst_n    (RST_N),
        .async_in (EVENT_INPUT_PIN),
        .level    (ev_level),
        .rise     (ev_rise),
        .fall     (ev_fall)
    );

    udrt_sync_edge u_ud
    (
        .clk      (CLK),
        .rst_n    (RST_N),
        .async_in (COUNT_DIRECTION_PIN),
        .level    (ud_level),
        .rise     (),
        .fall     ()
    );

    // Watch clock is unrelated to CLK; up to one CLK period of jitter
    udrt_sync_edge u_w4
    (
        .clk      (CLK),
        .rst_n    (RST_N),
        .async_in (WATCH_CLK_DIV4),
        .level    (),
        .rise     (w4_rise),
        .fall     ()
    );

    assign clock_source_select = timer_mode_ctl_ff[`UDRT_CSEL_MSB:`UDRT_CSEL_LSB];
    assign autoreload_select   = timer_mode_ctl_ff[`UDRT_BIT_AUTORELOAD];
    // Writes commit on the edge the master sees waitrequest low
    assign load_write = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0]
                        & (AVS_ADDRESS == `UDRT_ADDR_COUNT);

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            presc_ff <= 13'h0000;
        else
            presc_ff <= presc_ff + 13'h0001;
    end

    always @*
    begin
        case (clock_source_select)
            3'h0: tick = presc_tap(presc_ff, DIV_8192);
            3'h1: tick = presc_tap(presc_ff, `UDRT_DIV_2048);
            3'h2: tick = presc_tap(presc_ff, `UDRT_DIV_512);
            3'h3: tick = presc_tap(presc_ff, `UDRT_DIV_64);
            3'h4: tick = presc_tap(presc_ff, `UDRT_DIV_16);
            3'h5: tick = presc_tap(presc_ff, `UDRT_DIV_4);
            `UDRT_CSEL_WATCH4: tick = w4_rise;
            `UDRT_CSEL_EXT: tick = EVENT_EDGE_RISING ? ev_rise : ev_fall;
            default: tick = 1'b0;
        endcase
        // Subclock modes: system prescaler keeps running but its taps give no tick
        if (SUB_MODE && clock_source_select != `UDRT_CSEL_WATCH4
            && clock_source_select != `UDRT_CSEL_EXT)
            tick = 1'b0;
    end

    always @*
    begin
        if (timer_mode_ctl_ff[`UDRT_BIT_HW_DIR])
            down = ud_level;
        else
            down = timer_mode_ctl_ff[`UDRT_BIT_SW_DIR];
    end

    always @*
    begin
        nxt_count = count_value_ff;
        wrap = 1'b0;
        if (tick)
        begin
            wrap = down ? (count_value_ff == 8'h00) : (count_value_ff == 8'hFF);
            if (wrap && autoreload_select)
                nxt_count = reload_value_ff;
            else if (SUB_MODE && WATCH_SUB_DIV8
                     && clock_source_select == `UDRT_CSEL_WATCH4)
                // Slow subclock: LSB frozen, count steps by two
                nxt_count = down ? count_value_ff - 8'h02
                                 : count_value_ff + 8'h02;
            else
                nxt_count = down ? count_value_ff - 8'h01
                                 : count_value_ff + 8'h01;
        end
        if (load_write)
            nxt_count = AVS_WRITEDATA[7:0];
    end

    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            timer_mode_ctl_ff <= `UDRT_MODE_RESET;
            reload_value_ff   <= `UDRT_RELOAD_RESET;
            count_value_ff    <= `UDRT_COUNT_RESET;
            WRAP_PULSE        <= 1'b0;
            COUNT_VALUE       <= 8'h00;
            COUNT_DOWN        <= 1'b0;
        end
        else
        begin
            count_value_ff <= nxt_count;
            COUNT_VALUE    <= nxt_count;
            COUNT_DOWN     <= down;
            WRAP_PULSE     <= wrap & ~load_write;
            if (load_write)
                reload_value_ff <= AVS_WRITEDATA[7:0];
            if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
                && AVS_ADDRESS == `UDRT_ADDR_MODE)
                timer_mode_ctl_ff <= AVS_WRITEDATA[7:0] | `UDRT_MODE_RSVD_MASK;
        end
    end

    // One wait cycle, then acknowledge; reload register is write-only
    always @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ack_ff          <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
        end
        else
        begin
            ack_ff          <= (AVS_READ | AVS_WRITE) & ~ack_ff;
            AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_ff);
            AVS_READDATA    <= 32'h00000000;
            if (AVS_READ && !ack_ff)
            begin
                case (AVS_ADDRESS)
                    `UDRT_ADDR_MODE:   AVS_READDATA <= {24'h000000, timer_mode_ctl_ff};
                    `UDRT_ADDR_COUNT:  AVS_READDATA <= {24'h000000, count_value_ff};
                    `UDRT_ADDR_STATUS: AVS_READDATA <= {29'h00000000, ev_level,
                                                        ud_level, down};
                    default:           AVS_READDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // udrt_timer

//--- tb/udrt_pins.sv
/* Far-side pin model: event pulses, direction level, free watch clock.
   Assumes the timer's system clock as its reference. */
`timescale 1ns/1ns
module udrt_pins
(
    input  wire clk,
    input  wire dn,
    output reg  ev,
    output reg  dir,
    output reg  wclk
);
    reg [2:0] ph_ff = 3'h0;
    initial {ev, dir, wclk} = 3'h0;
    always @(posedge clk)
    begin
        ph_ff <= ph_ff + 3'h1;
        wclk  <= ph_ff[2];
        dir   <= dn;
    end
    // Slow pulses so the synchroniser never drops an edge
    task pulse(input [3:0] n);
        repeat (n)
        begin
            ev <= 1'h1;
            repeat (4) @(posedge clk);
            ev <= 1'h0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule // udrt_pins

//--- tb/udrt_timer_sva.sv
/* Port checker of the up/down reload timer.
   Assumes binding to udrt_timer; mode and reload shadowed from writes. */
`timescale 1ns/1ns
module udrt_timer_sva
(
    input wire        CLK,
    input wire        RST_N,
    input wire [1:0]  AVS_ADDRESS,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0]  AVS_BYTEENABLE,
    input wire [31:0] AVS_READDATA,
    input wire        AVS_WAITREQUEST,
    input wire        COUNT_DIRECTION_PIN,
    input wire        WRAP_PULSE,
    input wire [7:0]  COUNT_VALUE,
    input wire        COUNT_DOWN
);
    reg  [7:0] mode_ff;
    reg  [7:0] rld_ff;
    wire       wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    always @(posedge CLK or negedge RST_N)
        if (!RST_N)
            mode_ff <= 8'h18;
        else if (wr_ok && AVS_ADDRESS == 2'h0)
            mode_ff <= AVS_WRITEDATA[7:0];
    always @(posedge CLK or negedge RST_N)
        if (!RST_N)
            rld_ff <= 8'h00;
        else if (wr_ok && AVS_ADDRESS == 2'h1)
            rld_ff <= AVS_WRITEDATA[7:0];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_hw;
        (mode_ff[6] && $stable(COUNT_DIRECTION_PIN))[*6];
    endsequence
    sequence s_sw;
        (!mode_ff[6] && $stable(mode_ff))[*3];
    endsequence
    a_load_count: assert property (wr_ok && AVS_ADDRESS == 2'h1 |=>
        COUNT_VALUE == rld_ff) else $error("counter not loaded");
    a_auto_reload: assert property (WRAP_PULSE && mode_ff[7] |->
        COUNT_VALUE == rld_ff) else $error("no reload on wrap");
    a_interval_wrap: assert property (WRAP_PULSE && !mode_ff[7] |->
        COUNT_VALUE == ~$past(COUNT_VALUE)) else $error("bad wrap value");
    a_wrap_cause: assert property (WRAP_PULSE |->
        $past(COUNT_VALUE) == {8{!$past(COUNT_DOWN)}}) else $error("bad wrap");
    a_pulse_one: assert property (WRAP_PULSE |=> !WRAP_PULSE)
        else $error("wrap pulse too long");
    a_read_live: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 2'h1
        |-> AVS_READDATA == {24'h0, COUNT_VALUE} || AVS_READDATA == {24'h0,
        $past(COUNT_VALUE)}) else $error("read not live counter");
    a_reset_state: assert property ($rose(RST_N) |-> COUNT_VALUE == 8'h00
        && !COUNT_DOWN && AVS_WAITREQUEST) else $error("bad reset state");
    a_hw_dir: assert property (s_hw |-> COUNT_DOWN == COUNT_DIRECTION_PIN)
        else $error("pin direction ignored");
    a_sw_dir: assert property (s_sw |-> COUNT_DOWN == mode_ff[5])
        else $error("software direction ignored");
endmodule // udrt_timer_sva
bind udrt_timer udrt_timer_sva chk (.*);

//--- tb/tb_udrt_timer.sv
/* Bench of the up/down reload timer: bus task, scenarios, verdict.
   Assumes the longest prescaler tap shortened to 16 cycles. */
`timescale 1ns/1ns
module tb_udrt_timer;
    reg         CLK = 1'h0, RST_N = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
    reg  [1:0]  AVS_ADDRESS = 2'h0;
    reg  [31:0] AVS_WRITEDATA = 32'h0;
    reg  [3:0]  AVS_BYTEENABLE = 4'hF;
    reg         EVENT_EDGE_RISING = 1'h1, SUB_MODE = 1'h0, WATCH_SUB_DIV8 = 1'h0;
    reg         dn = 1'h0;
    wire [31:0] AVS_READDATA;
    wire        AVS_WAITREQUEST, WRAP_PULSE, COUNT_DOWN, EVENT_INPUT_PIN;
    wire        COUNT_DIRECTION_PIN, WATCH_CLK_DIV4;
    wire [7:0]  COUNT_VALUE;
    reg  [31:0] q;
    integer     failures = 0, n_compared = 0, cyc = 0;
    udrt_timer #(.DIV_8192(16)) uut (.*);
    udrt_pins pins (.clk(CLK), .dn(dn), .ev(EVENT_INPUT_PIN),
        .dir(COUNT_DIRECTION_PIN), .wclk(WATCH_CLK_DIV4));
    always #25 CLK = ~CLK;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                failures = failures + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task bus(input rd, input [1:0] a, input [7:0] d);
        begin
            @(posedge CLK);
            AVS_READ <= rd;
            AVS_WRITE <= !rd;
            AVS_ADDRESS <= a;
            AVS_WRITEDATA <= {24'h0, d};
            @(posedge CLK);
            while (AVS_WAITREQUEST !== 1'h0)
                @(posedge CLK);
            q = AVS_READDATA;
            AVS_READ <= 1'h0;
            AVS_WRITE <= 1'h0;
            // Let the committing edge settle before callers look
            @(negedge CLK);
        end
    endtask
    task wwrap;
        begin
            @(posedge CLK);
            while (WRAP_PULSE !== 1'h1)
                @(posedge CLK);
        end
    endtask
    task t_reset;
        begin
            bus(1'h1, 2'h0, 8'h00);
            chk(q, 32'h18);
            bus(1'h1, 2'h3, 8'h00);
            chk(q, 32'h0);
        end
    endtask
    task t_interval;
        begin
            bus(1'h0, 2'h0, 8'h05);
            bus(1'h0, 2'h1, 8'hFD);
            chk(COUNT_VALUE, 8'hFD);
            wwrap;
            chk(COUNT_VALUE, 8'h00);
            bus(1'h0, 2'h0, 8'h25);
            bus(1'h0, 2'h1, 8'h01);
            wwrap;
            chk(COUNT_VALUE, 8'hFF);
        end
    endtask
    task t_auto;
        begin
            bus(1'h0, 2'h0, 8'h85);
            bus(1'h0, 2'h1, 8'hFE);
            wwrap;
            chk(COUNT_VALUE, 8'hFE);
            bus(1'h0, 2'h0, 8'hA5);
            wwrap;
            chk(COUNT_VALUE, 8'hFE);
        end
    endtask
    task t_event;
        begin
            bus(1'h0, 2'h0, 8'h07); // Pin routed, ext irq masked outside
            bus(1'h0, 2'h1, 8'h5A);
            bus(1'h1, 2'h1, 8'h00);
            chk(q, 32'h5A);
            pins.pulse(4'h5);
            repeat (8) @(posedge CLK);
            chk(COUNT_VALUE, 8'h5F);
            bus(1'h1, 2'h1, 8'h00);
            chk(q, 32'h5F);
        end
    endtask
    task t_dir;
        begin
            bus(1'h0, 2'h0, 8'h45); // Direction pin function assumed on
            dn <= 1'h1;
            repeat (8) @(posedge CLK);
            chk(COUNT_DOWN, 1'h1);
            dn <= 1'h0;
            repeat (8) @(posedge CLK);
            chk(COUNT_DOWN, 1'h0);
        end
    endtask
    task t_sub;
        begin
            SUB_MODE <= 1'h1;
            bus(1'h0, 2'h0, 8'h05);
            bus(1'h0, 2'h1, 8'h10);
            repeat (40) @(posedge CLK);
            chk(COUNT_VALUE, 8'h10);
            WATCH_SUB_DIV8 <= 1'h1;
            bus(1'h0, 2'h0, 8'h06);
            repeat (40) @(posedge CLK);
            chk(COUNT_VALUE[0], 1'h0);
            chk(COUNT_VALUE == 8'h10, 1'h0);
        end
    endtask
    task close_out;
        begin
            $display("failures %0d compared %0d", failures, n_compared);
            if (failures == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Run is under 1500 cycles, mostly the down count in t_auto; ceiling leaves wide margin
    always @(posedge CLK)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            close_out;
        end
    end
    initial
    begin
        repeat (8) @(posedge CLK);
        RST_N <= 1'h1;
        t_reset;
        t_interval;
        t_auto;
        t_event;
        t_dir;
        t_sub;
        close_out;
    end
endmodule // tb_udrt_timer
